// ==== logic/perf_event_defines.vh ====
// constants for the second-level cache and bus event counting block
`ifndef PERF_EVENT_DEFINES_VH
`define PERF_EVENT_DEFINES_VH
`define BANK_COUNT 4
`define BANK_SEL_WIDTH 2
`define BLOCK_REFS 4'h8
`define SINGLE_REF 4'h1
`define COMMIT_MAX 3'h4
`define COMMIT_WIDTH 3
`define INC_WIDTH 4
`define TAG_WIDTH 16
`define MSHR_DEPTH 8
`endif

// ==== logic/ref_classify.v ====
// classifies one cache reference into demand or prefetch increments
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_defines.vh"
module ref_classify (
  input wire clk_i,
  input wire sys_rst_i,
  input wire ref_valid_i,
  input wire ref_external_i,
  input wire ref_hw_prefetch_i,
  input wire ref_got_resources_i,
  input wire ref_block_i,
  output reg [`INC_WIDTH-1:0] demand_inc_o,
  output reg [`INC_WIDTH-1:0] prefetch_inc_o,
  output reg is_demand_o
);
  wire demand_cls;
  wire [`INC_WIDTH-1:0] amount;
  // hardware prefetch or no resources means prefetch
  assign demand_cls = ref_got_resources_i & ~ref_hw_prefetch_i;
  assign amount = ref_block_i ? `BLOCK_REFS : `SINGLE_REF;
  always @(*) begin
    is_demand_o = demand_cls;
  end
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      demand_inc_o <= 4'h0;
      prefetch_inc_o <= 4'h0;
    end else begin
      // external references never count as demand
      demand_inc_o <= (ref_valid_i & ~ref_external_i & demand_cls) ?
        amount : 4'h0;
      prefetch_inc_o <= (ref_valid_i & ~ref_external_i & ~demand_cls) ?
        amount : 4'h0;
    end
  end
endmodule // ref_classify
`default_nettype wire

// ==== logic/bank_popcount.v ====
// sums per-bank one-bit pulses into a single count
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_defines.vh"
module bank_popcount #(
  parameter N = `BANK_COUNT
) (
  input wire [N-1:0] bits_i,
  output reg [`COMMIT_WIDTH-1:0] sum_o
);
  integer k;
  always @(*) begin
    sum_o = 3'h0;
    for (k = 0; k < N; k = k + 1) begin
      sum_o = sum_o + {2'b00, bits_i[k]};
    end
  end
endmodule // bank_popcount
`default_nettype wire

// ==== logic/l2_bus_perf_event_counters.v ====
// event pulse generation for second-level cache and bus transactions
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_defines.vh"
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - demand references counted, block op adds eight
// - prefetch references counted, block op adds eight
// - external references never raise demand references
// - demand miss equals sum of bank misses
// - prefetch miss equals sum of bank misses
// - separate demand miss pulse per bank
// - separate prefetch miss pulse per bank
// - demand merging into pending prefetch: no miss
// - latency adds each outstanding demand access
// - merged demand latency counts from its arrival
// - demand and prefetch writebacks counted separately
// - prefetch dropped on full port counted
// - prefetch dropped by pipeline abort counted
// - processor memory reads and writes counted
// - input/output memory reads counted
// - input/output write event counts full stores
// - partial-store input/output writes counted separately
// - external invalidate counted only on cache hit
// - external bus events shared by all cores
// - external copy-read counted only on hit
// - commit count classified up to three
// - core events per core, external chip-wide
// - demand means request obtained memory resources
// - no resources or hardware prefetch means prefetch
module l2_bus_perf_event_counters #(
  parameter NUM_CORES = 4,
  parameter CORE_SEL_WIDTH = 2,
  parameter NUM_BANKS = `BANK_COUNT,
  parameter DEPTH = `MSHR_DEPTH,
  parameter IDX_WIDTH = 3
) (
  input wire clk_i,
  input wire sys_rst_i,
  // cache pipeline reference
  input wire ref_valid_i,
  input wire [CORE_SEL_WIDTH-1:0] ref_core_i,
  input wire ref_external_i,
  input wire ref_hw_prefetch_i,
  input wire ref_got_resources_i,
  input wire ref_block_i,
  input wire ref_miss_i,
  input wire ref_writeback_i,
  input wire [`BANK_SEL_WIDTH-1:0] ref_bank_i,
  input wire [`TAG_WIDTH-1:0] ref_tag_i,
  // memory data return
  input wire fill_valid_i,
  input wire [`TAG_WIDTH-1:0] fill_tag_i,
  // prefetch losses
  input wire prefetch_port_full_drop_i,
  input wire prefetch_abort_drop_i,
  input wire [CORE_SEL_WIDTH-1:0] drop_core_i,
  // bus requests
  input wire cpu_mem_read_i,
  input wire cpu_mem_write_i,
  input wire io_mem_read_i,
  input wire io_mem_write_i,
  input wire io_write_partial_i,
  input wire ext_invalidate_i,
  input wire ext_copy_read_i,
  input wire ext_hit_i,
  // commit width per core
  input wire [NUM_CORES*`COMMIT_WIDTH-1:0] commit_count_i,
  // per-core outputs
  output reg [NUM_CORES*`INC_WIDTH-1:0] l2_demand_ref_event_o,
  output reg [NUM_CORES*`INC_WIDTH-1:0] l2_prefetch_ref_event_o,
  output reg [NUM_CORES*`COMMIT_WIDTH-1:0] l2_demand_miss_event_o,
  output reg [NUM_CORES*`COMMIT_WIDTH-1:0] l2_prefetch_miss_event_o,
  output reg [NUM_CORES*NUM_BANKS-1:0] bank_demand_miss_event_o,
  output reg [NUM_CORES*NUM_BANKS-1:0] bank_prefetch_miss_event_o,
  output reg [NUM_CORES*NUM_BANKS*4-1:0] bank_demand_latency_event_o,
  output reg [NUM_CORES-1:0] demand_writeback_event_o,
  output reg [NUM_CORES-1:0] prefetch_writeback_event_o,
  output reg [NUM_CORES-1:0] prefetch_drop_port_full_o,
  output reg [NUM_CORES-1:0] prefetch_drop_abort_o,
  output reg [NUM_CORES*4-1:0] commit_class_o,
  // chip-wide outputs
  output reg cpu_mem_read_event_o,
  output reg cpu_mem_write_event_o,
  output reg io_mem_read_event_o,
  output reg full_store_write_o,
  output reg partial_store_write_o,
  output reg external_invalidate_event_o,
  output reg external_copy_read_event_o
);
  //////////////////////////////////////////////////////////////////////////
  // reference classification
  wire [`INC_WIDTH-1:0] dm_inc;
  wire [`INC_WIDTH-1:0] pf_inc;
  wire is_demand;
  reg [CORE_SEL_WIDTH-1:0] ref_core_reg;
  ref_classify u_classify (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ref_valid_i(ref_valid_i),
    .ref_external_i(ref_external_i),
    .ref_hw_prefetch_i(ref_hw_prefetch_i),
    .ref_got_resources_i(ref_got_resources_i),
    .ref_block_i(ref_block_i),
    .demand_inc_o(dm_inc),
    .prefetch_inc_o(pf_inc),
    .is_demand_o(is_demand)
  );
  //////////////////////////////////////////////////////////////////////////
  // outstanding miss table
  reg [DEPTH-1:0] ent_valid_reg;
  reg [DEPTH-1:0] ent_demand_reg;
  reg [`TAG_WIDTH-1:0] ent_tag_reg [0:DEPTH-1];
  reg [`BANK_SEL_WIDTH-1:0] ent_bank_reg [0:DEPTH-1];
  reg [CORE_SEL_WIDTH-1:0] ent_core_reg [0:DEPTH-1];
  reg [DEPTH-1:0] tag_match;
  reg [DEPTH-1:0] fill_match;
  reg [IDX_WIDTH-1:0] free_idx;
  reg free_found;
  wire core_ref;
  wire pending_pf_hit;
  wire new_miss;
  wire merge;
  integer i;
  integer j;
  assign core_ref = ref_valid_i & ~ref_external_i;
  always @(*) begin
    tag_match = {DEPTH{1'b0}};
    fill_match = {DEPTH{1'b0}};
    free_idx = {IDX_WIDTH{1'b0}};
    free_found = 1'b0;
    for (i = 0; i < DEPTH; i = i + 1) begin
      tag_match[i] = ent_valid_reg[i] & ~ent_demand_reg[i] &
        (ent_tag_reg[i] == ref_tag_i);
      fill_match[i] = ent_valid_reg[i] & (ent_tag_reg[i] == fill_tag_i);
      if (!ent_valid_reg[i] && !free_found) begin
        free_idx = i[IDX_WIDTH-1:0];
        free_found = 1'b1;
      end
    end
  end
  assign pending_pf_hit = |tag_match;
  // a demand hitting a pending prefetch miss is a merge, not a miss
  assign merge = core_ref & is_demand & ref_miss_i & pending_pf_hit;
  assign new_miss = core_ref & ref_miss_i & ~merge;
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      ent_valid_reg <= {DEPTH{1'b0}};
      ent_demand_reg <= {DEPTH{1'b0}};
      ref_core_reg <= {CORE_SEL_WIDTH{1'b0}};
    end else begin
      ref_core_reg <= ref_core_i;
      for (j = 0; j < DEPTH; j = j + 1) begin
        if (fill_valid_i && fill_match[j]) begin
          ent_valid_reg[j] <= 1'b0;
        end else if (merge && tag_match[j]) begin
          // latency starts now for the merged demand
          ent_demand_reg[j] <= 1'b1;
          ent_core_reg[j] <= ref_core_i;
        end
      end
      if (new_miss && free_found) begin
        ent_valid_reg[free_idx] <= 1'b1;
        ent_demand_reg[free_idx] <= is_demand;
        ent_tag_reg[free_idx] <= ref_tag_i;
        ent_bank_reg[free_idx] <= ref_bank_i;
        ent_core_reg[free_idx] <= ref_core_i;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // per-bank latency: number of outstanding demand accesses per bank
  reg [NUM_CORES*NUM_BANKS*4-1:0] lat_next;
  integer c;
  integer b;
  integer m;
  always @(*) begin
    lat_next = {NUM_CORES*NUM_BANKS*4{1'b0}};
    c = 0;
    b = 0;
    for (m = 0; m < DEPTH; m = m + 1) begin
      if (ent_valid_reg[m] && ent_demand_reg[m]) begin
        c = ent_core_reg[m];
        b = ent_bank_reg[m];
        // every overlapping access adds its own cycle
        lat_next[(c*NUM_BANKS+b)*4 +: 4] =
          lat_next[(c*NUM_BANKS+b)*4 +: 4] + 4'h1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // per-core miss, writeback and drop pulses
  reg [NUM_CORES*NUM_BANKS-1:0] bank_dm_next;
  reg [NUM_CORES*NUM_BANKS-1:0] bank_pf_next;
  genvar g;
  generate
    for (g = 0; g < NUM_CORES; g = g + 1) begin : g_core
      wire sel;
      wire [`COMMIT_WIDTH-1:0] dm_sum;
      wire [`COMMIT_WIDTH-1:0] pf_sum;
      wire [`COMMIT_WIDTH-1:0] cc;
      assign sel = (ref_core_i == g);
      always @(*) begin
        bank_dm_next[g*NUM_BANKS +: NUM_BANKS] = {NUM_BANKS{1'b0}};
        bank_pf_next[g*NUM_BANKS +: NUM_BANKS] = {NUM_BANKS{1'b0}};
        if (new_miss && sel) begin
          if (is_demand) begin
            bank_dm_next[g*NUM_BANKS + ref_bank_i] = 1'b1;
          end else begin
            bank_pf_next[g*NUM_BANKS + ref_bank_i] = 1'b1;
          end
        end
      end
      bank_popcount #(.N(NUM_BANKS)) u_dm_sum (
        .bits_i(bank_dm_next[g*NUM_BANKS +: NUM_BANKS]),
        .sum_o(dm_sum)
      );
      bank_popcount #(.N(NUM_BANKS)) u_pf_sum (
        .bits_i(bank_pf_next[g*NUM_BANKS +: NUM_BANKS]),
        .sum_o(pf_sum)
      );
      assign cc = commit_count_i[g*`COMMIT_WIDTH +: `COMMIT_WIDTH];
      always @(posedge clk_i) begin
        if (sys_rst_i) begin
          l2_demand_ref_event_o[g*4 +: 4] <= 4'h0;
          l2_prefetch_ref_event_o[g*4 +: 4] <= 4'h0;
          l2_demand_miss_event_o[g*3 +: 3] <= 3'h0;
          l2_prefetch_miss_event_o[g*3 +: 3] <= 3'h0;
          demand_writeback_event_o[g] <= 1'b0;
          prefetch_writeback_event_o[g] <= 1'b0;
          prefetch_drop_port_full_o[g] <= 1'b0;
          prefetch_drop_abort_o[g] <= 1'b0;
          commit_class_o[g*4 +: 4] <= 4'h0;
        end else begin
          // classifier output is one cycle behind its inputs
          l2_demand_ref_event_o[g*4 +: 4] <=
            (ref_core_reg == g) ? dm_inc : 4'h0;
          l2_prefetch_ref_event_o[g*4 +: 4] <=
            (ref_core_reg == g) ? pf_inc : 4'h0;
          l2_demand_miss_event_o[g*3 +: 3] <= dm_sum;
          l2_prefetch_miss_event_o[g*3 +: 3] <= pf_sum;
          demand_writeback_event_o[g] <= new_miss & sel & is_demand &
            ref_writeback_i;
          prefetch_writeback_event_o[g] <= new_miss & sel & ~is_demand &
            ref_writeback_i;
          prefetch_drop_port_full_o[g] <= prefetch_port_full_drop_i &
            (drop_core_i == g);
          prefetch_drop_abort_o[g] <= prefetch_abort_drop_i &
            (drop_core_i == g);
          // one-hot of 0..3 commits, values of four and above give zero
          commit_class_o[g*4 +: 4] <= (cc == 3'h0) ? 4'h1 :
            (cc == 3'h1) ? 4'h2 : (cc == 3'h2) ? 4'h4 :
            (cc == 3'h3) ? 4'h8 : 4'h0;
        end
      end
    end
  endgenerate
  //////////////////////////////////////////////////////////////////////////
  // bank pulses, latency and chip-wide bus events
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      bank_demand_miss_event_o <= {NUM_CORES*NUM_BANKS{1'b0}};
      bank_prefetch_miss_event_o <= {NUM_CORES*NUM_BANKS{1'b0}};
      bank_demand_latency_event_o <= {NUM_CORES*NUM_BANKS*4{1'b0}};
      cpu_mem_read_event_o <= 1'b0;
      cpu_mem_write_event_o <= 1'b0;
      io_mem_read_event_o <= 1'b0;
      full_store_write_o <= 1'b0;
      partial_store_write_o <= 1'b0;
      external_invalidate_event_o <= 1'b0;
      external_copy_read_event_o <= 1'b0;
    end else begin
      bank_demand_miss_event_o <= bank_dm_next;
      bank_prefetch_miss_event_o <= bank_pf_next;
      bank_demand_latency_event_o <= lat_next;
      cpu_mem_read_event_o <= cpu_mem_read_i;
      cpu_mem_write_event_o <= cpu_mem_write_i;
      io_mem_read_event_o <= io_mem_read_i;
      full_store_write_o <= io_mem_write_i & ~io_write_partial_i;
      partial_store_write_o <= io_mem_write_i & io_write_partial_i;
      // single chip-wide pulse seen identically by every core
      external_invalidate_event_o <= ext_invalidate_i & ext_hit_i;
      external_copy_read_event_o <= ext_copy_read_i & ext_hit_i;
    end
  end
endmodule // l2_bus_perf_event_counters
`default_nettype wire

// ==== test/l2_perf_monitor.sv ====
// assertions on the event pulse block ports
`timescale 1ns/1ps
`default_nettype none
module l2_perf_monitor #(
  parameter NUM_CORES = 4,
  parameter NUM_BANKS = 4
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ref_valid_i,
  input wire logic ref_external_i,
  input wire logic ref_block_i,
  input wire logic [1:0] ref_core_i,
  input wire logic [NUM_CORES*4-1:0] l2_demand_ref_event_o,
  input wire logic [NUM_CORES*4-1:0] l2_prefetch_ref_event_o,
  input wire logic [NUM_CORES*3-1:0] l2_demand_miss_event_o,
  input wire logic [NUM_CORES*3-1:0] l2_prefetch_miss_event_o,
  input wire logic [NUM_CORES*NUM_BANKS-1:0] bank_demand_miss_event_o,
  input wire logic [NUM_CORES*NUM_BANKS-1:0] bank_prefetch_miss_event_o,
  input wire logic io_mem_write_i,
  input wire logic io_write_partial_i,
  input wire logic full_store_write_o,
  input wire logic partial_store_write_o,
  input wire logic ext_invalidate_i,
  input wire logic ext_hit_i,
  input wire logic external_invalidate_event_o,
  input wire logic prefetch_port_full_drop_i,
  input wire logic [1:0] drop_core_i,
  input wire logic [NUM_CORES-1:0] prefetch_drop_port_full_o,
  input wire logic [NUM_CORES*3-1:0] commit_count_i,
  input wire logic [NUM_CORES*4-1:0] commit_class_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_ext_no_ref: assert property (
    ref_valid_i && ref_external_i |-> ##2
    l2_demand_ref_event_o == '0 && l2_prefetch_ref_event_o == '0)
    else $error("external reference gave an increment");
  a_block_eight: assert property (
    ref_valid_i && !ref_external_i && ref_block_i |-> ##2
    (((l2_demand_ref_event_o | l2_prefetch_ref_event_o)
    >> (4 * $past(ref_core_i, 2))) & 4'hf) == 4'h8)
    else $error("block reference did not add eight");
  genvar g;
  for (g = 0; g < NUM_CORES; g = g + 1) begin : g_sum
    a_demand_sum: assert property (
      l2_demand_miss_event_o[3*g +: 3] ==
      $countones(bank_demand_miss_event_o[NUM_BANKS*g +: NUM_BANKS]))
      else $error("demand miss differs from bank sum");
    a_prefetch_sum: assert property (
      l2_prefetch_miss_event_o[3*g +: 3] ==
      $countones(bank_prefetch_miss_event_o[NUM_BANKS*g +: NUM_BANKS]))
      else $error("prefetch miss differs from bank sum");
  end
  a_store_split: assert property (
    io_mem_write_i |=> full_store_write_o == !$past(io_write_partial_i)
    && partial_store_write_o == $past(io_write_partial_i))
    else $error("io write went to the wrong event");
  a_inval_hit: assert property (
    ext_invalidate_i |=> external_invalidate_event_o == $past(ext_hit_i))
    else $error("invalidate event ignores presence");
  a_drop_core: assert property (
    prefetch_port_full_drop_i |=>
    prefetch_drop_port_full_o == (1 << $past(drop_core_i)))
    else $error("port full drop on wrong core");
  a_commit_class: assert property (
    !$past(sys_rst_i) |=> commit_class_o[3:0] ==
    ($past(commit_count_i[2:0]) > 3'h3 ? 4'h0
    : 4'h1 << $past(commit_count_i[2:0])))
    else $error("commit class wrong for core zero");
endmodule // l2_perf_monitor
`default_nettype wire

// ==== test/l2_fill_model.sv ====
// memory side model returning fill data after a set latency
`timescale 1ns/1ps
`default_nettype none
module l2_fill_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic miss_i,
  input wire logic [15:0] tag_i,
  input wire logic [3:0] lat_i,
  output logic fill_valid_o,
  output logic [15:0] fill_tag_o
);
  logic [15:0] tag_q[$];
  int due_q[$];
  int cyc = 0;
  initial begin
    fill_valid_o = 1'b0;
    fill_tag_o = 16'h0;
  end
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (sys_rst_i) begin
      tag_q.delete();
      due_q.delete();
    end else if (miss_i) begin
      tag_q.push_back(tag_i);
      due_q.push_back(cyc + lat_i - 1);
    end
  end
  // idle tag flips so a stale value is never mistaken for a fill
  always @(negedge clk_i) begin
    if (due_q.size() > 0 && due_q[0] <= cyc) begin
      fill_valid_o <= 1'b1;
      fill_tag_o <= tag_q.pop_front();
      void'(due_q.pop_front());
    end else begin
      fill_valid_o <= 1'b0;
      fill_tag_o <= ~fill_tag_o;
    end
  end
endmodule // l2_fill_model
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the event pulse block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ref_valid_i, ref_external_i, ref_hw_prefetch_i, ref_got_resources_i;
  logic ref_block_i, ref_miss_i, ref_writeback_i, fill_valid_i;
  logic [1:0] ref_core_i, ref_bank_i, drop_core_i;
  logic [15:0] ref_tag_i, fill_tag_i, tag_n = 16'h0100;
  logic prefetch_port_full_drop_i, prefetch_abort_drop_i, cpu_mem_read_i;
  logic cpu_mem_write_i, io_mem_read_i, io_mem_write_i, io_write_partial_i;
  logic ext_invalidate_i, ext_copy_read_i, ext_hit_i;
  logic [11:0] commit_count_i, l2_demand_miss_event_o, l2_prefetch_miss_event_o;
  logic [15:0] l2_demand_ref_event_o, l2_prefetch_ref_event_o, commit_class_o;
  logic [15:0] bank_demand_miss_event_o, bank_prefetch_miss_event_o;
  logic [63:0] bank_demand_latency_event_o;
  logic [3:0] demand_writeback_event_o, prefetch_writeback_event_o;
  logic [3:0] prefetch_drop_port_full_o, prefetch_drop_abort_o;
  logic cpu_mem_read_event_o, cpu_mem_write_event_o, io_mem_read_event_o;
  logic full_store_write_o, partial_store_write_o, external_invalidate_event_o;
  logic external_copy_read_event_o;
  logic [3:0] fill_lat = 4'h1;
  logic [31:0] seed = 32'h5e;
  logic [31:0] corner[4] = '{32'h1b, 32'h3fd, 32'h92400039, 32'h1e0000};
  int bad_count = 0;
  int tests_run = 0;

  always #5 clk_i = ~clk_i;

  l2_bus_perf_event_counters i_l2_bus_perf_event_counters (
    .clk_i, .sys_rst_i, .ref_valid_i, .ref_core_i, .ref_external_i,
    .ref_hw_prefetch_i, .ref_got_resources_i, .ref_block_i, .ref_miss_i,
    .ref_writeback_i, .ref_bank_i, .ref_tag_i, .fill_valid_i, .fill_tag_i,
    .prefetch_port_full_drop_i, .prefetch_abort_drop_i, .drop_core_i,
    .cpu_mem_read_i, .cpu_mem_write_i, .io_mem_read_i, .io_mem_write_i,
    .io_write_partial_i, .ext_invalidate_i, .ext_copy_read_i, .ext_hit_i,
    .commit_count_i, .l2_demand_ref_event_o, .l2_prefetch_ref_event_o,
    .l2_demand_miss_event_o, .l2_prefetch_miss_event_o,
    .bank_demand_miss_event_o, .bank_prefetch_miss_event_o,
    .bank_demand_latency_event_o, .demand_writeback_event_o,
    .prefetch_writeback_event_o, .prefetch_drop_port_full_o,
    .prefetch_drop_abort_o, .commit_class_o, .cpu_mem_read_event_o,
    .cpu_mem_write_event_o, .io_mem_read_event_o, .full_store_write_o,
    .partial_store_write_o, .external_invalidate_event_o,
    .external_copy_read_event_o
  );
  l2_fill_model i_l2_fill_model (
    .clk_i, .sys_rst_i, .miss_i(ref_valid_i & ref_miss_i & ~ref_external_i),
    .tag_i(ref_tag_i), .lat_i(fill_lat), .fill_valid_o(fill_valid_i),
    .fill_tag_o(fill_tag_i)
  );

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apply(input logic [31:0] r);
    {ext_hit_i, ext_copy_read_i, ext_invalidate_i, io_write_partial_i,
     io_mem_write_i, io_mem_read_i, cpu_mem_write_i, cpu_mem_read_i,
     drop_core_i, prefetch_abort_drop_i, prefetch_port_full_drop_i,
     ref_bank_i, ref_core_i, ref_miss_i, ref_block_i, ref_got_resources_i,
     ref_hw_prefetch_i, ref_external_i, ref_valid_i} = r[21:0];
    ref_writeback_i = r[22] & r[5];
    commit_count_i = r[31:20];
    ref_tag_i = tag_n;
    tag_n++;
  endtask
  task automatic idle;
    {ref_valid_i, ref_miss_i, prefetch_port_full_drop_i, cpu_mem_read_i,
     prefetch_abort_drop_i, cpu_mem_write_i, io_mem_read_i, io_mem_write_i,
     ext_invalidate_i, ext_copy_read_i} = '0;
  endtask
  // one reference plus bus traffic, fill returns the cycle after
  task automatic step(input logic [31:0] r);
    logic dem, mv;
    logic [3:0] inc, idx;
    logic [15:0] cls;
    integer c;
    apply(r);
    dem = ref_got_resources_i & ~ref_hw_prefetch_i;
    mv = ref_valid_i & ~ref_external_i & ref_miss_i;
    inc = ref_block_i ? 4'h8 : 4'h1;
    if (!ref_valid_i || ref_external_i)
      inc = 4'h0;
    idx = {ref_core_i, ref_bank_i};
    for (c = 0; c < 4; c++)
      cls[4*c +: 4] = commit_count_i[3*c +: 3] > 3'h3 ? 4'h0
        : 4'h1 << commit_count_i[3*c +: 3];
    @(negedge clk_i);
    check("bank dm", 64'(mv & dem) << idx, bank_demand_miss_event_o);
    check("bank pf", 64'(mv & ~dem) << idx, bank_prefetch_miss_event_o);
    check("dm sum", 64'(mv & dem) << 3*ref_core_i, l2_demand_miss_event_o);
    check("pf sum", 64'(mv & ~dem) << 3*ref_core_i, l2_prefetch_miss_event_o);
    check("writeback", 8'(mv & ref_writeback_i) << (dem ? ref_core_i
      : ref_core_i + 3'h4), {prefetch_writeback_event_o,
      demand_writeback_event_o});
    check("drops", {4'(prefetch_abort_drop_i) << drop_core_i,
      4'(prefetch_port_full_drop_i) << drop_core_i},
      {prefetch_drop_abort_o, prefetch_drop_port_full_o});
    check("commit", cls, commit_class_o);
    check("bus", {cpu_mem_read_i, cpu_mem_write_i, io_mem_read_i,
      io_mem_write_i & ~io_write_partial_i, io_mem_write_i & io_write_partial_i,
      ext_invalidate_i & ext_hit_i, ext_copy_read_i & ext_hit_i},
      {cpu_mem_read_event_o, cpu_mem_write_event_o, io_mem_read_event_o,
      full_store_write_o, partial_store_write_o, external_invalidate_event_o,
      external_copy_read_event_o});
    idle;
    @(negedge clk_i);
    check("dm ref", 64'(dem ? inc : 4'h0) << 4*ref_core_i,
      l2_demand_ref_event_o);
    check("pf ref", 64'(dem ? 4'h0 : inc) << 4*ref_core_i,
      l2_prefetch_ref_event_o);
    check("latency", 64'(mv & dem) << 4*idx, bank_demand_latency_event_o);
  endtask
  // directed miss on core 1 bank 2
  task automatic miss_ref(input logic got, input logic [15:0] tag);
    apply(32'h00000261 | 32'(got) << 3);
    ref_tag_i = tag;
    @(negedge clk_i);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    apply(32'h0);
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    @(negedge clk_i);
    foreach (corner[i])
      step(corner[i]);
    repeat (300) begin
      repeat (5) seed = lfsr(seed);
      step(seed);
    end
    fill_lat = 4'h6;
    miss_ref(1'b0, 16'haaaa);
    miss_ref(1'b1, 16'haaaa);
    check("merged miss", 64'h0, bank_demand_miss_event_o);
    check("pf latency", 64'h0, bank_demand_latency_event_o);
    miss_ref(1'b1, 16'hbbbb);
    idle;
    @(negedge clk_i);
    check("overlap", 64'h2 << 24, bank_demand_latency_event_o);
    repeat (4) @(negedge clk_i);
    check("one left", 64'h1 << 24, bank_demand_latency_event_o);
    repeat (2) @(negedge clk_i);
    check("drained", 64'h0, bank_demand_latency_event_o);
    results;
  end
  // about 620 cycles expected, limit well above that
  initial begin
    #20000;
    bad_count++;
    results;
  end
endmodule // testbench

bind l2_bus_perf_event_counters l2_perf_monitor #(
  .NUM_CORES(NUM_CORES), .NUM_BANKS(NUM_BANKS)
) i_l2_perf_monitor (
  .clk_i, .sys_rst_i, .ref_valid_i, .ref_external_i, .ref_block_i,
  .ref_core_i, .l2_demand_ref_event_o, .l2_prefetch_ref_event_o,
  .l2_demand_miss_event_o, .l2_prefetch_miss_event_o,
  .bank_demand_miss_event_o, .bank_prefetch_miss_event_o, .io_mem_write_i,
  .io_write_partial_i, .full_store_write_o, .partial_store_write_o,
  .ext_invalidate_i, .ext_hit_i, .external_invalidate_event_o,
  .prefetch_port_full_drop_i, .drop_core_i, .prefetch_drop_port_full_o,
  .commit_count_i, .commit_class_o
);
`default_nettype wire
